// File: verilog/phy_mgmt_defs.svh
// Purpose: constants of the phy management controller block
// Assumes: 100 MHz mclk, AXI4-Lite register port, 32-bit data
// Notes: per controller a 64-byte window, controller index in addr[7:6]
`ifndef PHY_MGMT_DEFS_SVH
`define PHY_MGMT_DEFS_SVH

`define NUM_CTL 3
`define CLK_HZ 100000000
`define MDC_MAX_HZ 25000000
`define MDC_MIN_HALF ((`CLK_HZ + 2 * `MDC_MAX_HZ - 1) / (2 * `MDC_MAX_HZ))

// register byte offsets inside one controller window
`define OFS_STATUS 6'h00
`define OFS_CMD 6'h04
`define OFS_DATA 6'h08
`define OFS_CFG 6'h0C
`define OFS_SCAN_RANGE 6'h10
`define OFS_SCAN_CMP 6'h14
`define OFS_LAST 6'h18
`define OFS_LAST_VLD 6'h1C
`define OFS_STICKY 6'h20
`define ADDR_CTL 7:6
`define ADDR_OFS 5:0

// command fields
`define CMD_VALID 31
`define CMD_PHY 30:26
`define CMD_REG 25:21
`define CMD_OP 20:19
`define CMD_SCAN 18
`define CMD_ONE_PASS 17
`define CMD_WDATA 15:0
`define OP_READ_BIT 1

// configuration fields and reset values
`define CFG_PRESCALE 7:0
`define CFG_START 9:8
`define CFG_PRESCALE_RST 8'h18
`define CFG_START_RST 2'h1

// scan range and compare fields
`define RANGE_LO 4:0
`define RANGE_HI 12:8
`define CMP_MASK 15:0
`define CMP_EXPECT 31:16

// status and data fields
`define ST_RD_PEND 0
`define ST_WR_PEND 1
`define ST_OPR_PEND 2
`define ST_BUSY 3
`define ST_SCAN 4
`define DATA_OK 16

// frame layout and queue depth
`define PREAMBLE 32'hFFFF_FFFF
`define TA_DRIVE 2'h2
`define FRAME_BITS 7'h40
`define TA_FIRST 7'h2E
`define TA_LAST 7'h2F
`define QDEPTH 2'h2

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: verilog/phy_mgmt_pkg.sv
// Purpose: types of the phy management controller block
// Assumes: constants come from phy_mgmt_defs.svh
// Notes: none
package phy_mgmt_pkg;

	typedef struct packed {
		logic [1:0] op;
		logic [4:0] phy;
		logic [4:0] regad;
		logic [15:0] wdata;
	} cmd_t;

	// gray along idle, low, high
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOW = 2'h1,
		ST_HIGH = 2'h3
	} eng_state_t;

endpackage : phy_mgmt_pkg

// File: verilog/phy_management_controller.sv
// Purpose: three phy management bus masters behind AXI4-Lite
// Assumes: mdio pin level synchronised here; phy answers before mdc falls
// Notes: writes merge under wstrb; unmapped access answers SLVERR
`timescale 1ns/100ps
`include "phy_mgmt_defs.svh"

module phy_management_controller (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic [`NUM_CTL-1:0] mdc,
	output logic [`NUM_CTL-1:0] mdio_out,
	output logic [`NUM_CTL-1:0] mdio_oe,
	input wire logic [`NUM_CTL-1:0] mdio_in,
	output logic [`NUM_CTL-1:0] irq
);

////////////////////////////////////////////////////////////////////////////////
// bus slave

logic [7:0] aw_q;
logic [31:0] wd_q;
logic [3:0] ws_q;
logic awf_q;
logic wf_q;
logic awready_q;
logic wready_q;
logic bvalid_q;
logic [1:0] bresp_q;
logic arready_q;
logic rvalid_q;
logic [31:0] rdata_q;
logic [1:0] rresp_q;
logic [31:0] rword_w [`NUM_CTL];
logic [31:0] rword_r [`NUM_CTL];

wire aw_hs = awvalid && awready_q;
wire w_hs = wvalid && wready_q;
wire ar_hs = arvalid && arready_q;
wire do_wr = awf_q && wf_q && !bvalid_q;
wire awf_d = awf_q ? !do_wr : aw_hs;
wire wf_d = wf_q ? !do_wr : w_hs;
wire rvalid_d = rvalid_q ? !rready : ar_hs;
wire [1:0] wc = aw_q[`ADDR_CTL];
wire [1:0] rc = araddr[`ADDR_CTL];
wire w_map = (wc < 2'(`NUM_CTL)) && (aw_q[1:0] == 2'h0)
	&& (aw_q[`ADDR_OFS] <= `OFS_STICKY);
wire r_map = (rc < 2'(`NUM_CTL)) && (araddr[1:0] == 2'h0)
	&& (araddr[`ADDR_OFS] <= `OFS_STICKY);
wire [31:0] bmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}},
	{8{ws_q[0]}}};
wire [31:0] w_old = w_map ? rword_w[wc] : 32'h0000_0000;
wire [31:0] w_val = (w_old & ~bmask) | (wd_q & bmask);

always_ff @(posedge mclk or negedge resetn) begin
	if (!resetn) begin
		awf_q <= 1'b0;
		wf_q <= 1'b0;
		awready_q <= 1'b0;
		wready_q <= 1'b0;
		aw_q <= 8'h00;
		wd_q <= 32'h0000_0000;
		ws_q <= 4'h0;
	end else begin
		awf_q <= awf_d;
		wf_q <= wf_d;
		awready_q <= !awf_d;
		wready_q <= !wf_d;
		if (aw_hs) begin
			aw_q <= awaddr;
		end
		if (w_hs) begin
			wd_q <= wdata;
			ws_q <= wstrb;
		end
	end
end

always_ff @(posedge mclk or negedge resetn) begin
	if (!resetn) begin
		bvalid_q <= 1'b0;
		bresp_q <= `RESP_OKAY;
	end else if (do_wr) begin
		bvalid_q <= 1'b1;
		bresp_q <= w_map ? `RESP_OKAY : `RESP_SLVERR;
	end else if (bready) begin
		bvalid_q <= 1'b0;
	end
end

always_ff @(posedge mclk or negedge resetn) begin
	if (!resetn) begin
		arready_q <= 1'b0;
		rvalid_q <= 1'b0;
		rdata_q <= 32'h0000_0000;
		rresp_q <= `RESP_OKAY;
	end else begin
		arready_q <= !rvalid_d;
		rvalid_q <= rvalid_d;
		if (ar_hs) begin
			rdata_q <= r_map ? rword_r[rc] : 32'h0000_0000;
			rresp_q <= r_map ? `RESP_OKAY : `RESP_SLVERR;
		end
	end
end

assign awready = awready_q;
assign wready = wready_q;
assign bvalid = bvalid_q;
assign bresp = bresp_q;
assign arready = arready_q;
assign rvalid = rvalid_q;
assign rdata = rdata_q;
assign rresp = rresp_q;

////////////////////////////////////////////////////////////////////////////////
// controllers

for (genvar i = 0; i < `NUM_CTL; i++) begin : g_ctl
	logic [31:0] cmd_q;
	logic [9:0] cfg_q;
	logic [12:0] range_q;
	logic [31:0] cmp_q;
	logic [15:0] rdw_q;
	logic ok_q;
	logic [31:0] last_q;
	logic [31:0] lvld_q;
	logic [31:0] sticky_q;
	logic irq_q;
	logic scan_on_q;
	logic [4:0] scan_phy_q;
	phy_mgmt_pkg::cmd_t q_mem [`QDEPTH];
	logic q_wp_q;
	logic q_rp_q;
	logic [1:0] q_cnt_q;
	logic [1:0] rd_n_q;
	logic [1:0] wr_n_q;
	phy_mgmt_pkg::eng_state_t st_q;
	phy_mgmt_pkg::cmd_t cur_q;
	logic cur_scan_q;
	logic [63:0] frame_q;
	logic [6:0] bit_q;
	logic [8:0] hc_q;
	logic [15:0] rx_q;
	logic ta_q;
	logic mdc_q;
	logic mdo_q;
	logic oe_q;
	logic sync1_q;
	logic sync2_q;
	wire busy = (st_q != phy_mgmt_pkg::ST_IDLE) || (q_cnt_q != 2'h0)
		|| scan_on_q;

	function automatic logic [31:0] rdreg(input logic [5:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			`OFS_STATUS: begin
				r[`ST_RD_PEND] = rd_n_q != 2'h0;
				r[`ST_WR_PEND] = wr_n_q != 2'h0;
				r[`ST_OPR_PEND] = q_cnt_q == `QDEPTH;
				r[`ST_BUSY] = busy;
				r[`ST_SCAN] = scan_on_q;
			end
			`OFS_CMD: begin
				r = cmd_q;
				r[`CMD_VALID] = q_cnt_q != 2'h0;
			end
			`OFS_DATA: r = {15'h0000, ok_q, rdw_q};
			`OFS_CFG: r = {22'h00_0000, cfg_q};
			`OFS_SCAN_RANGE: r = {19'h0_0000, range_q};
			`OFS_SCAN_CMP: r = cmp_q;
			`OFS_LAST: r = last_q;
			`OFS_LAST_VLD: r = lvld_q;
			`OFS_STICKY: r = sticky_q;
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction : rdreg

	wire wr_me = do_wr && w_map && (wc == 2'(i));
	wire wr_cmd = wr_me && (aw_q[`ADDR_OFS] == `OFS_CMD);
	wire go = wr_cmd && w_val[`CMD_VALID];
	wire [1:0] new_op = w_val[`CMD_OP];
	wire scan_go = go && w_val[`CMD_SCAN] && new_op[`OP_READ_BIT];
	wire single_go = go && !w_val[`CMD_SCAN];
	wire push = single_go && (q_cnt_q != `QDEPTH);
	wire rd_clr = ar_hs && r_map && (rc == 2'(i))
		&& (araddr[`ADDR_OFS] == `OFS_STICKY);
	wire idle = st_q == phy_mgmt_pkg::ST_IDLE;
	wire pop = idle && (q_cnt_q != 2'h0);
	wire scan_start = idle && (q_cnt_q == 2'h0) && scan_on_q;
	wire start = pop || scan_start;
	wire [8:0] half_raw = {1'b0, cfg_q[`CFG_PRESCALE]} + 9'h001;
	wire [8:0] half = (half_raw < 9'(`MDC_MIN_HALF))
		? 9'(`MDC_MIN_HALF) : half_raw;
	wire tick = hc_q == 9'h001;
	wire fall = (st_q == phy_mgmt_pkg::ST_HIGH) && tick;
	wire fin = fall && (bit_q == `FRAME_BITS);
	wire cur_rd = cur_q.op[`OP_READ_BIT];
	wire [15:0] rd_word = {rx_q[14:0], sync2_q};
	wire rd_ok = !ta_q;
	wire [15:0] cmask = cmp_q[`CMP_MASK];
	wire mism = |((rd_word ^ cmp_q[`CMP_EXPECT]) & cmask);
	wire scan_fin = fin && cur_scan_q;
	wire [31:0] phy_bit = 32'h0000_0001 << cur_q.phy;
	wire [31:0] hit = scan_fin ? phy_bit : 32'h0000_0000;
	wire [31:0] sticky_d = (rd_clr ? 32'hFFFF_FFFF : sticky_q)
		& ~(mism ? hit : 32'h0000_0000);
	phy_mgmt_pkg::cmd_t nxt;
	phy_mgmt_pkg::cmd_t new_cmd;

	assign new_cmd = '{op: w_val[`CMD_OP], phy: w_val[`CMD_PHY],
		regad: w_val[`CMD_REG], wdata: w_val[`CMD_WDATA]};
	assign nxt = pop ? q_mem[q_rp_q] : phy_mgmt_pkg::cmd_t'{
		op: cmd_q[`CMD_OP], phy: scan_phy_q, regad: cmd_q[`CMD_REG],
		wdata: 16'h0000};
	always_comb rword_w[i] = rdreg(aw_q[`ADDR_OFS]);
	always_comb rword_r[i] = rdreg(araddr[`ADDR_OFS]);

	// software registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cmd_q <= 32'h0000_0000;
			cfg_q <= {`CFG_START_RST, `CFG_PRESCALE_RST};
			range_q <= 13'h0000;
			cmp_q <= 32'h0000_0000;
		end else if (wr_me) begin
			case (aw_q[`ADDR_OFS])
				`OFS_CMD: cmd_q <= w_val;
				`OFS_CFG: cfg_q <= w_val[9:0];
				`OFS_SCAN_RANGE: range_q <= w_val[12:0];
				`OFS_SCAN_CMP: cmp_q <= w_val;
				default: cmd_q <= cmd_q;
			endcase
		end
	end

	// command queue and pending counts
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			q_wp_q <= 1'b0;
			q_rp_q <= 1'b0;
			q_cnt_q <= 2'h0;
			rd_n_q <= 2'h0;
			wr_n_q <= 2'h0;
		end else begin
			if (push) begin
				q_mem[q_wp_q] <= new_cmd;
				q_wp_q <= !q_wp_q;
			end
			if (pop) begin
				q_rp_q <= !q_rp_q;
			end
			q_cnt_q <= q_cnt_q + 2'(push) - 2'(pop);
			rd_n_q <= rd_n_q + 2'(push && new_cmd.op[`OP_READ_BIT])
				- 2'(fin && !cur_scan_q && cur_rd);
			wr_n_q <= wr_n_q + 2'(push && !new_cmd.op[`OP_READ_BIT])
				- 2'(fin && !cur_scan_q && !cur_rd);
		end
	end

	// scan sequencing
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			scan_on_q <= 1'b0;
			scan_phy_q <= 5'h00;
		end else if (scan_go) begin
			scan_on_q <= 1'b1;
			scan_phy_q <= range_q[`RANGE_LO];
		end else if (single_go) begin
			scan_on_q <= 1'b0;
		end else if (scan_fin && scan_on_q) begin
			if (cur_q.phy == range_q[`RANGE_HI]) begin
				scan_on_q <= !cmd_q[`CMD_ONE_PASS];
				scan_phy_q <= range_q[`RANGE_LO];
			end else begin
				scan_phy_q <= cur_q.phy + 5'h01;
			end
		end
	end

	// results
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdw_q <= 16'h0000;
			ok_q <= 1'b0;
			last_q <= 32'hFFFF_FFFF;
			lvld_q <= 32'h0000_0000;
			sticky_q <= 32'hFFFF_FFFF;
			irq_q <= 1'b0;
		end else begin
			if (fin && cur_rd) begin
				rdw_q <= rd_word;
				ok_q <= rd_ok;
			end
			if (scan_fin) begin
				last_q <= mism ? last_q & ~phy_bit : last_q | phy_bit;
				lvld_q <= rd_ok ? lvld_q | phy_bit : lvld_q & ~phy_bit;
			end
			sticky_q <= sticky_d;
			irq_q <= !(&sticky_d);
		end
	end

	// pin synchroniser
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= mdio_in[i];
			sync2_q <= sync1_q;
		end
	end

	// frame engine
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_q <= phy_mgmt_pkg::ST_IDLE;
			cur_q <= '0;
			cur_scan_q <= 1'b0;
			frame_q <= 64'h0000_0000_0000_0000;
			bit_q <= 7'h00;
			hc_q <= 9'h000;
			rx_q <= 16'h0000;
			ta_q <= 1'b1;
			mdc_q <= 1'b0;
			mdo_q <= 1'b1;
			oe_q <= 1'b0;
		end else begin
			case (st_q)
				phy_mgmt_pkg::ST_IDLE: begin
					if (start) begin
						st_q <= phy_mgmt_pkg::ST_LOW;
						cur_q <= nxt;
						cur_scan_q <= !pop;
						frame_q <= {`PREAMBLE, cfg_q[`CFG_START], nxt.op,
							nxt.phy, nxt.regad, `TA_DRIVE,
							nxt.wdata} << 1;
						mdo_q <= 1'b1;
						oe_q <= 1'b1;
						bit_q <= 7'h01;
						hc_q <= half;
					end
				end
				phy_mgmt_pkg::ST_LOW: begin
					hc_q <= tick ? half : hc_q - 9'h001;
					if (tick) begin
						st_q <= phy_mgmt_pkg::ST_HIGH;
						mdc_q <= 1'b1;
					end
				end
				phy_mgmt_pkg::ST_HIGH: begin
					hc_q <= tick ? half : hc_q - 9'h001;
					if (tick) begin
						mdc_q <= 1'b0;
						if (bit_q - 7'h01 == `TA_LAST) begin
							ta_q <= sync2_q;
						end
						if (bit_q - 7'h01 > `TA_LAST) begin
							rx_q <= rd_word;
						end
						if (fin) begin
							st_q <= phy_mgmt_pkg::ST_IDLE;
							oe_q <= 1'b0;
							mdo_q <= 1'b1;
						end else begin
							st_q <= phy_mgmt_pkg::ST_LOW;
							mdo_q <= frame_q[63];
							frame_q <= frame_q << 1;
							oe_q <= !(cur_rd && bit_q >= `TA_FIRST);
							bit_q <= bit_q + 7'h01;
						end
					end
				end
				default: st_q <= phy_mgmt_pkg::ST_IDLE;
			endcase
		end
	end

	assign mdc[i] = mdc_q;
	assign mdio_out[i] = mdo_q;
	assign mdio_oe[i] = oe_q;
	assign irq[i] = irq_q;
end

endmodule : phy_management_controller

// File: testbench/phy_mgmt_phy_model.sv
// Purpose: phy answering management frames on one data line
// Assumes: pull-up on the line; read bits driven just after mdc rises
// Notes: read word is reply xor phy address; frame keeps all 64 bits
`timescale 1ns/100ps

module phy_mgmt_phy_model (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic mdc,
	input wire logic oe,
	input wire logic line,
	input wire logic [15:0] reply,
	output logic drive_oe,
	output logic drive_val,
	output logic [63:0] frame,
	output logic [7:0] nframes
);
	logic mdc_q;
	logic oe_q;
	logic [6:0] cnt;
	logic [4:0] ph;
	logic [15:0] word;
	logic nxt;

	assign word = reply ^ {11'h000, ph};
	// released turnaround bit reads as the pull-up
	assign nxt = (cnt == 7'h2F) ? 1'b0 :
		(cnt > 7'h2F) ? word[~cnt[3:0]] : 1'b1;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mdc_q <= 1'b0;
			oe_q <= 1'b0;
			cnt <= 7'h40;
			ph <= 5'h00;
			frame <= 64'h0000_0000_0000_0000;
			nframes <= 8'h00;
			drive_oe <= 1'b0;
			drive_val <= 1'b1;
		end else begin
			mdc_q <= mdc;
			oe_q <= oe;
			if (oe && !oe_q)
				cnt <= 7'h00;
			else if (mdc && !mdc_q && cnt != 7'h40) begin
				cnt <= cnt + 7'h01;
				frame <= {frame[62:0], oe ? line : nxt};
				drive_oe <= !oe && cnt > 7'h2E;
				drive_val <= nxt;
				if (cnt == 7'h2E)
					ph <= frame[9:5];
			end else if (!mdc && mdc_q && cnt == 7'h40) begin
				drive_oe <= 1'b0;
				nframes <= nframes + 8'h01;
				cnt <= 7'h41;
			end
		end
	end
endmodule : phy_mgmt_phy_model

// File: testbench/phy_mgmt_asserts.sv
// Purpose: port checks of the phy management controller
// Assumes: one mclk domain, resetn active low
// Notes: bound to the top module
`timescale 1ns/100ps
`include "phy_mgmt_defs.svh"

module phy_mgmt_asserts (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [`NUM_CTL-1:0] mdc,
	input wire logic [`NUM_CTL-1:0] mdio_out,
	input wire logic [`NUM_CTL-1:0] mdio_oe
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_b_late;
		!bvalid ##1 bvalid;
	endsequence

	a_b_latency: assert property (s_wr_taken |=> s_b_late)
		else $error("write answer late");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_r_latency: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");

	for (genvar c = 0; c < `NUM_CTL; c++) begin : g_ctl
		a_mdc_high: assert property ($rose(mdc[c]) |=> mdc[c])
			else $error("mdc high too short");
		a_mdc_low: assert property ($fell(mdc[c]) |=> !mdc[c])
			else $error("mdc low too short");
		a_data_fall: assert property ($changed(mdio_out[c]) ||
			$fell(mdio_oe[c]) |-> $fell(mdc[c]))
			else $error("data moved off mdc fall");
		a_frame_start: assert property ($rose(mdio_oe[c]) |->
			!mdc[c] && mdio_out[c])
			else $error("frame start wrong");
	end
endmodule : phy_mgmt_asserts

bind phy_management_controller phy_mgmt_asserts phy_mgmt_asserts_i (
	.mclk(mclk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rvalid(rvalid), .rready(rready), .mdc(mdc), .mdio_out(mdio_out),
	.mdio_oe(mdio_oe)
);

// File: testbench/tb_phy_management_controller.sv
// Purpose: self-checking bench of the phy management controller
// Assumes: pull-up on every management data line
// Notes: controller 0 carries most traffic, 1 the extended format
`timescale 1ns/100ps
`include "phy_mgmt_defs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end

module tb_phy_management_controller;
	logic mclk, resetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [2:0] mdc, mdio_out, mdio_oe, irq;
	wire [2:0] mdio_in, phy_oe, phy_val;
	wire [63:0] fr [3];
	wire [7:0] nfr [3];
	logic [15:0] reply;
	int checks, bad_count;

	phy_management_controller phy_management_controller_i (
		.mclk(mclk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.mdio_in(mdio_in), .irq(irq));

	for (genvar c = 0; c < 3; c++) begin : g_phy
		assign mdio_in[c] = mdio_oe[c] ? mdio_out[c] :
			(phy_oe[c] ? phy_val[c] : 1'b1);
		phy_mgmt_phy_model phy_mgmt_phy_model_i (
			.mclk(mclk), .resetn(resetn), .mdc(mdc[c]), .oe(mdio_oe[c]),
			.line(mdio_in[c]), .reply(reply), .drive_oe(phy_oe[c]),
			.drive_val(phy_val[c]), .frame(fr[c]), .nframes(nfr[c]));
	end

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	task test_done;
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic stall;
		bad_count++;
		$display("[ERR] %0t wait ran out", $time);
		test_done();
	endtask : stall

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (n < 50 && bvalid !== 1'b1) begin
			@(posedge mclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		if (n == 50)
			stall();
		bready <= 1'b0;
		`CHK(bresp, 2'h0)
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (n < 50 && rvalid !== 1'b1) begin
			@(posedge mclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end
		if (n == 50)
			stall();
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK(d, e)
	endtask : rdc

	task automatic wait_fr(input int c, input logic [7:0] t);
		int n;
		for (n = 0; n < 12000 && nfr[c] !== t; n++)
			@(posedge mclk);
		if (n == 12000)
			stall();
	endtask : wait_fr

	task automatic quiet(input int c, input logic [7:0] t);
		repeat (3400) @(posedge mclk);
		`CHK(nfr[c], t)
	endtask : quiet

	function automatic logic [31:0] cmd(logic [4:0] p, logic [4:0] g,
		logic [1:0] op, logic [1:0] sc, logic [15:0] v);
		return {1'b1, p, g, op, sc, 1'b0, v};
	endfunction : cmd

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rdc(8'h0C, 32'h0000_0118);
		rdc(8'h18, 32'hFFFF_FFFF);
		rdc(8'h1C, 32'h0000_0000);
		rd(8'hC0);
		`CHK(r, 2'h2)
	endtask : t_reset

	task automatic t_write;
		wr(8'h0C, 32'h0000_0100);
		wr(8'h04, cmd(5'h05, 5'h03, 2'h1, 2'h0, 16'hA5C3));
		rd(8'h00);
		`CHK(d[1], 1'b1)
		rd(8'h04);
		`CHK(d[31], 1'b0)
		wait_fr(0, 8'h01);
		`CHK(fr[0], {32'hFFFF_FFFF, 4'h5, 5'h05, 5'h03, 2'h2, 16'hA5C3})
		rdc(8'h00, 32'h0000_0000);
		wr(8'h0C, 32'h0000_0118);
	endtask : t_write

	task automatic t_read;
		wr(8'h04, cmd(5'h07, 5'h02, 2'h2, 2'h0, 16'h0000));
		rd(8'h00);
		`CHK(d[0], 1'b1)
		wait_fr(0, 8'h02);
		rdc(8'h08, 32'h0001_1237);
		`CHK(fr[0], {32'hFFFF_FFFF, 4'h6, 5'h07, 5'h02, 2'h2, 16'h1237})
	endtask : t_read

	task automatic t_queue;
		for (int i = 1; i < 4; i++)
			wr(8'h04, cmd(5'(i), 5'h00, 2'h2, 2'h0, 16'h0000));
		rd(8'h00);
		`CHK(d[2], 1'b1)
		wr(8'h04, cmd(5'h04, 5'h00, 2'h1, 2'h0, 16'h0000));
		wait_fr(0, 8'h05);
		quiet(0, 8'h05);
		rdc(8'h08, 32'h0001_1233);
	endtask : t_queue

	task automatic t_scan;
		wr(8'h10, 32'h0000_0402);
		wr(8'h14, 32'hF233_000F);
		wr(8'h04, cmd(5'h09, 5'h01, 2'h2, 2'h3, 16'h0000));
		for (int i = 0; i < 3; i++) begin
			wait_fr(0, 8'h06 + 8'(i));
			`CHK(fr[0][27:23], 5'(2 + i))
			`CHK(fr[0][22:18], 5'h01)
		end
		quiet(0, 8'h08);
		rdc(8'h18, 32'hFFFF_FFEB);
		rdc(8'h1C, 32'h0000_001C);
		`CHK(irq, 3'h1)
		rdc(8'h20, 32'hFFFF_FFEB);
		rdc(8'h20, 32'hFFFF_FFFF);
		`CHK(irq, 3'h0)
	endtask : t_scan

	task automatic t_ext;
		wr(8'h4C, 32'h0000_0018);
		wr(8'h44, cmd(5'h01, 5'h03, 2'h0, 2'h0, 16'h0042));
		wait_fr(1, 8'h01);
		`CHK(fr[1], {32'hFFFF_FFFF, 4'h0, 5'h01, 5'h03, 2'h2, 16'h0042})
		`CHK(nfr[0], 8'h08)
	endtask : t_ext

	////////////////////////////////////////////////////////////////////////
	initial begin
		{resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		reply = 16'h1230;
		checks = 0;
		bad_count = 0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		repeat (2) @(posedge mclk);
		t_reset();
		t_write();
		t_read();
		t_queue();
		t_scan();
		t_ext();
		test_done();
	end
endmodule : tb_phy_management_controller
